// file: design/rtcx_hours_alarm.sv
// Purpose: Hours counter, interval alarm, crystal trim and pin config.
// Assumes: Tick and config inputs come from same-clock RTC logic.
// Notes:   arst_n_i is power-on reset; soft_rst_i is watchdog/pin reset.
`default_nettype none
`include "rtcx_regs.svh"
module rtcx_hours_alarm
    import rtcx_pkg::*;
(
    input wire logic clk_i,              // 200 MHz clock
    input wire logic arst_n_i,           // Power-on reset, async
    input wire logic soft_rst_i,         // Watchdog/pin reset, sync
    input wire logic [7:0] sfr_addr_i,   // SFR address
    input wire logic sfr_wr_i,           // SFR write strobe
    input wire logic sfr_rd_i,           // SFR read strobe
    input wire logic [7:0] sfr_wdata_i,  // SFR write data
    output logic [7:0] sfr_rdata_o,      // SFR read data, one cycle late
    input wire rtcx_clkcfg_t clk_cfg_i,  // Clock config fields
    input wire logic minute_carry_i,     // Minutes rollover pulse
    input wire logic tick_128hz_i,       // 128 Hz pulse
    input wire logic [3:0] timebase_tick_i, // Interval base pulses
    input wire logic [3:0] cal_wave_i,   // Calibration waves by select
    input wire logic day_flag_clr_i,     // Software clears day flag
    input wire logic alarm_flag_clr_i,   // Software clears alarm flag
    input wire logic ext_irq0_pin_i,     // External irq0 pin
    input wire logic ext_irq1_pin_i,     // External irq1 pin
    output logic day_flag_o,             // Day rollover flag
    output logic alarm_flag_o,           // Alarm flag
    output logic clock_irq_pend_o,       // Pending clock interrupt pulse
    output logic cal_output_pin_o,       // Calibration output level
    output logic cal_output_pin_oe_n_o,  // Low while pin driven
    output logic ext_irq0_o,             // Gated irq0 request
    output logic ext_irq1_o,             // Gated irq1 request
    output logic battery_control_input_o, // Pin as battery control
    output logic ext_irq1_gpio_o,        // Pin as general I/O
    output logic signed [7:0] comp_total_o // Clamped trim sum, 2 ppm LSB
);
    logic [7:0] hours_reg, hours_next;
    logic [7:0] intcmp_reg, intcmp_stage_reg;
    logic [7:0] key_reg, nomtrim_reg, tmptrim_reg, icnt_reg, icnt_inc;
    rtcx_pincfg_t pincfg_reg;
    logic [1:0] intcmp_pend_reg, irq0_sync_reg, irq1_sync_reg;
    logic day_evt, alarm_evt, unlocked, hour_wr, pincfg_wr;
    logic base_tick, icnt_match, icnt_hold_reg;
    logic signed [8:0] trim_sum;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = sfr_wr_i && (a == o);
    endfunction
    // ------------------------------------------------------------------
    // Key and protected writes
    // ------------------------------------------------------------------
    assign unlocked = (key_reg == `RTCX_KEY_UNLOCK);
    assign hour_wr = hit(sfr_addr_i, `RTCX_HOURS_ADDR) && unlocked;
    assign pincfg_wr = hit(sfr_addr_i, `RTCX_PINCFG_ADDR) && unlocked;
    // Key relocks after any protected write, so runaway code gets one shot
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            key_reg <= `RTCX_RST_BYTE;
        end else if (hit(sfr_addr_i, `RTCX_KEY_ADDR) && !soft_rst_i) begin
            key_reg <= sfr_wdata_i;
        end else if (soft_rst_i || hour_wr || pincfg_wr) begin
            key_reg <= `RTCX_RST_BYTE;
        end
    end
    // ------------------------------------------------------------------
    // Hours counter
    // ------------------------------------------------------------------
    always_comb begin
        day_evt = 1'b0;
        hours_next = hours_reg;
        if (minute_carry_i) begin
            if (clk_cfg_i.hour_format_select &&
                hours_reg >= `RTCX_HOUR_LAST_24) begin
                hours_next = `RTCX_RST_BYTE;
                day_evt = 1'b1;
            end else if (!clk_cfg_i.hour_format_select &&
                         hours_reg == `RTCX_HOUR_LAST_256) begin
                hours_next = `RTCX_RST_BYTE;
                day_evt = 1'b1;
            end else begin
                hours_next = hours_reg + 8'h01;
            end
        end
    end
    // Only power-on clears these; soft reset deliberately ignored
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hours_reg <= `RTCX_RST_BYTE;
            nomtrim_reg <= `RTCX_RST_BYTE;
            tmptrim_reg <= `RTCX_RST_BYTE;
        end else begin
            hours_reg <= hour_wr ? sfr_wdata_i : hours_next;
            if (hit(sfr_addr_i, `RTCX_NOMTRIM_ADDR)) begin
                nomtrim_reg <= sfr_wdata_i;
            end
            if (hit(sfr_addr_i, `RTCX_TMPTRIM_ADDR)) begin
                tmptrim_reg <= sfr_wdata_i;
            end
        end
    end
    // ------------------------------------------------------------------
    // Interval compare, applied on the 128 Hz domain edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            intcmp_reg <= `RTCX_RST_BYTE;
            intcmp_stage_reg <= `RTCX_RST_BYTE;
            intcmp_pend_reg <= 2'h0;
        end else if (soft_rst_i) begin
            intcmp_reg <= `RTCX_RST_BYTE;
            intcmp_stage_reg <= `RTCX_RST_BYTE;
            intcmp_pend_reg <= 2'h0;
        end else begin
            if (hit(sfr_addr_i, `RTCX_INTCMP_ADDR)) begin
                intcmp_stage_reg <= sfr_wdata_i;
                intcmp_pend_reg <= 2'h1;
            end else if (tick_128hz_i && intcmp_pend_reg != 2'h0) begin
                // Second tick applies: mimics two-stage 128 Hz sync
                intcmp_pend_reg <= intcmp_pend_reg + 2'h1;
                if (intcmp_pend_reg == 2'h2) begin
                    intcmp_reg <= intcmp_stage_reg;
                    intcmp_pend_reg <= 2'h0;
                end
            end
        end
    end
    // ------------------------------------------------------------------
    // Interval counter
    // ------------------------------------------------------------------
    assign base_tick = timebase_tick_i[clk_cfg_i.timebase_sel];
    assign icnt_inc = icnt_reg + 8'h01;
    assign icnt_match = icnt_inc == intcmp_reg;
    assign alarm_evt = clk_cfg_i.interval_enable && !icnt_hold_reg &&
                       base_tick && icnt_match;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            icnt_reg <= `RTCX_RST_BYTE;
            icnt_hold_reg <= 1'b0;
        end else if (soft_rst_i || !clk_cfg_i.interval_enable) begin
            icnt_reg <= `RTCX_RST_BYTE;
            icnt_hold_reg <= 1'b0;
        end else if (alarm_evt) begin
            icnt_reg <= `RTCX_RST_BYTE;
            icnt_hold_reg <= clk_cfg_i.single_interval;
        end else if (base_tick && !icnt_hold_reg) begin
            icnt_reg <= icnt_inc;
        end
    end
    // ------------------------------------------------------------------
    // Sticky flags and irq pulse; a set in the clear cycle wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            day_flag_o <= 1'b0;
            alarm_flag_o <= 1'b0;
            clock_irq_pend_o <= 1'b0;
        end else begin
            day_flag_o <= day_evt || (day_flag_o && !day_flag_clr_i);
            alarm_flag_o <= alarm_evt ||
                            (alarm_flag_o && !alarm_flag_clr_i);
            clock_irq_pend_o <= day_evt || alarm_evt;
        end
    end
    // ------------------------------------------------------------------
    // Pin configuration and pins
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pincfg_reg <= rtcx_pincfg_t'(`RTCX_RST_BYTE);
        end else if (soft_rst_i) begin
            pincfg_reg <= rtcx_pincfg_t'(`RTCX_RST_BYTE);
        end else if (pincfg_wr) begin
            pincfg_reg <= sfr_wdata_i;
        end
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq0_sync_reg <= 2'h0;
            irq1_sync_reg <= 2'h0;
            cal_output_pin_o <= 1'b0;
            cal_output_pin_oe_n_o <= 1'b1;
            ext_irq0_o <= 1'b0;
            ext_irq1_o <= 1'b0;
            battery_control_input_o <= 1'b0;
            ext_irq1_gpio_o <= 1'b0;
        end else begin
            irq0_sync_reg <= {irq0_sync_reg[0], ext_irq0_pin_i};
            irq1_sync_reg <= {irq1_sync_reg[0], ext_irq1_pin_i};
            cal_output_pin_oe_n_o <= !pincfg_reg.cal_output_enable;
            cal_output_pin_o <= pincfg_reg.cal_output_enable &&
                cal_wave_i[pincfg_reg.cal_freq_select];
            ext_irq0_o <= pincfg_reg.ext_irq0_function &&
                irq0_sync_reg[1];
            ext_irq1_o <= (pincfg_reg.ext_irq1_function[2:1] == 2'h3) &&
                irq1_sync_reg[1];
            battery_control_input_o <=
                (pincfg_reg.ext_irq1_function[1:0] == 2'h1) &&
                irq1_sync_reg[1];
            ext_irq1_gpio_o <= (pincfg_reg.ext_irq1_function[1:0] == 2'h0)
                && irq1_sync_reg[1];
        end
    end
    // ------------------------------------------------------------------
    // Compensation and read-back
    // ------------------------------------------------------------------
    assign trim_sum = $signed({nomtrim_reg[7], nomtrim_reg}) +
                      $signed({tmptrim_reg[7], tmptrim_reg});
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            comp_total_o <= 8'sh00;
            sfr_rdata_o <= `RTCX_RST_BYTE;
        end else begin
            if (trim_sum > `RTCX_TRIM_LIMIT) begin
                comp_total_o <= 8'sh7C;
            end else if (trim_sum < -`RTCX_TRIM_LIMIT) begin
                comp_total_o <= -8'sh7C;
            end else begin
                comp_total_o <= trim_sum[7:0];
            end
            if (sfr_rd_i) begin
                case (sfr_addr_i)
                    `RTCX_HOURS_ADDR: sfr_rdata_o <= hours_reg;
                    `RTCX_INTCMP_ADDR: sfr_rdata_o <= intcmp_reg;
                    `RTCX_KEY_ADDR: sfr_rdata_o <= key_reg;
                    `RTCX_NOMTRIM_ADDR: sfr_rdata_o <= nomtrim_reg;
                    `RTCX_TMPTRIM_ADDR: sfr_rdata_o <= tmptrim_reg;
                    `RTCX_PINCFG_ADDR: sfr_rdata_o <= pincfg_reg;
                    default: sfr_rdata_o <= `RTCX_RST_BYTE;
                endcase
            end
        end
    end
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    hour_step_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        minute_carry_i && !hour_wr && !day_evt |=>
        hours_reg == $past(hours_reg) + 8'h01)
        else $error("hours did not step");
    wrap_24_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        minute_carry_i && !hour_wr && clk_cfg_i.hour_format_select &&
        hours_reg == 8'h17 |=> hours_reg == 8'h00 && day_flag_o)
        else $error("24 hour wrap wrong");
    wrap_256_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        minute_carry_i && !hour_wr && !clk_cfg_i.hour_format_select &&
        hours_reg == 8'hFF |=> hours_reg == 8'h00 && clock_irq_pend_o)
        else $error("256 hour wrap wrong");
    soft_keep_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        soft_rst_i && !minute_carry_i && !sfr_wr_i |=> $stable(hours_reg) &&
        $stable(nomtrim_reg) && $stable(tmptrim_reg))
        else $error("soft reset disturbed retained state");
    alarm_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        alarm_evt |=> alarm_flag_o && clock_irq_pend_o && icnt_reg == 8'h00)
        else $error("alarm not raised");
    single_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        alarm_evt && clk_cfg_i.single_interval && !soft_rst_i ##1
        clk_cfg_i.interval_enable && !soft_rst_i |=> icnt_reg == 8'h00)
        else $error("single interval did not hold");
    key_guard_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        hit(sfr_addr_i, `RTCX_HOURS_ADDR) && key_reg != 8'hEA &&
        !minute_carry_i |=> $stable(hours_reg))
        else $error("unkeyed hours write took");
    intcmp_late_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        intcmp_pend_reg == 2'h1 && !tick_128hz_i && !sfr_wr_i &&
        !soft_rst_i |=> $stable(intcmp_reg))
        else $error("compare applied too early");
    flag_stick_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        day_flag_o && !day_flag_clr_i |=> day_flag_o)
        else $error("day flag dropped");
    trim_clamp_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 comp_total_o <= 8'sh7C && comp_total_o >= -8'sh7C)
        else $error("compensation out of range");
    cal_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !pincfg_reg.cal_output_enable |=> cal_output_pin_oe_n_o &&
        !cal_output_pin_o)
        else $error("cal pin driven while off");
endmodule
`default_nettype wire

// file: design/rtcx_pkg.sv
// Purpose: Types shared by the rtcx block.
// Assumes: Nothing beyond the register header.
// Notes:   Pin-config layout mirrors the header field positions.
`default_nettype none
package rtcx_pkg;
    typedef struct packed {
        logic       cal_output_enable;
        logic [1:0] cal_freq_select;
        logic       reserved;
        logic [2:0] ext_irq1_function;
        logic       ext_irq0_function;
    } rtcx_pincfg_t;

    typedef struct packed {
        logic       hour_format_select;
        logic       interval_enable;
        logic       single_interval;
        logic [1:0] timebase_sel;
    } rtcx_clkcfg_t;
endpackage
`default_nettype wire

// file: design/rtcx_regs.svh
// Purpose: Register offsets, field positions and reset values for rtcx.
// Assumes: 8-bit SFR addresses, 8-bit data.
// Notes:   Definitions only.
`ifndef RTCX_REGS_SVH
`define RTCX_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define RTCX_HOURS_ADDR     8'hA5
`define RTCX_INTCMP_ADDR    8'hA6
`define RTCX_KEY_ADDR       8'hC1
`define RTCX_NOMTRIM_ADDR   8'hF6
`define RTCX_TMPTRIM_ADDR   8'hF7
`define RTCX_PINCFG_ADDR    8'hFF

// ----------------------------------------------------------------------
// Values and fields
// ----------------------------------------------------------------------
`define RTCX_KEY_UNLOCK     8'hEA
`define RTCX_RST_BYTE       8'h00
`define RTCX_HOUR_LAST_24   8'h17
`define RTCX_HOUR_LAST_256  8'hFF
`define RTCX_TRIM_LIMIT     9'sh07C
`define RTCX_CAL_EN_BIT     7
`define RTCX_FSEL_HI        6
`define RTCX_FSEL_LO        5
`define RTCX_RSVD_BIT       4
`define RTCX_IRQ1_HI        3
`define RTCX_IRQ1_LO        1
`define RTCX_IRQ0_BIT       0

`endif

// file: testbench/rtcx_hours_alarm_tb.sv
// Purpose: Self-checking bench for rtcx_hours_alarm.
// Assumes: Inputs change at the falling edge; read data one cycle late.
// Notes:   Read results go through an expectation queue.
`default_nettype none
`include "rtcx_regs.svh"

module rtcx_hours_alarm_tb
    import rtcx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, arst_n = 1'b0, soft_rst = 1'b0;
    logic wr = 1'b0, rd = 1'b0, rd_seen = 1'b0, p0 = 1'b1, p1 = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pv = 8'h00;
    logic [7:0] h, v, n;
    logic [15:0] tv;
    logic [3:0] wave = 4'h0;
    logic [31:0] lfsr = 32'h37F94211;
    rtcx_clkcfg_t cfg = '0;
    logic day, alarm, irq, cal, cal_oe_n, i0, i1, bat, gpio;
    logic signed [7:0] comp;
    logic [7:0] exp_q[$];
    int failures = 0, num_checks = 0, irq_cnt = 0, cycles = 0;
    int sel, n0, w;

    always #2.5 clk = ~clk;

    rtcx_hours_alarm dut (.clk_i(clk), .arst_n_i(arst_n),
        .soft_rst_i(soft_rst), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .clk_cfg_i(cfg), .minute_carry_i(pv[0]), .tick_128hz_i(pv[1]),
        .timebase_tick_i(pv[5:2]), .cal_wave_i(wave),
        .day_flag_clr_i(pv[6]), .alarm_flag_clr_i(pv[7]),
        .ext_irq0_pin_i(p0), .ext_irq1_pin_i(p1), .day_flag_o(day),
        .alarm_flag_o(alarm), .clock_irq_pend_o(irq),
        .cal_output_pin_o(cal), .cal_output_pin_oe_n_o(cal_oe_n),
        .ext_irq0_o(i0), .ext_irq1_o(i1), .battery_control_input_o(bat),
        .ext_irq1_gpio_o(gpio), .comp_total_o(comp));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] clamp(input logic [7:0] a, b);
        int s;
        s = int'($signed(a)) + int'($signed(b));
        if (s > 124) s = 124;
        if (s < -124) s = -124;
        return s[7:0];
    endfunction

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk1(input string what, input logic e, input logic g);
        chk(what, {7'h00, e}, {7'h00, g});
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // Protected writes burn the key, so it is rewritten every time
    task automatic kwr(input logic [7:0] a, input logic [7:0] d);
        wr_reg(`RTCX_KEY_ADDR, `RTCX_KEY_UNLOCK);
        wr_reg(a, d);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        exp_q.push_back(e);
        @(negedge clk);
        rd = 1'b0;
    endtask

    task automatic pulse(input logic [7:0] m, input int cnt);
        repeat (cnt) begin
            @(negedge clk);
            pv = m;
            @(negedge clk);
            pv = 8'h00;
        end
    endtask

    task automatic idle(input int cnt);
        repeat (cnt) @(negedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) rd_seen <= rd;
    always @(posedge clk) if (irq === 1'b1) irq_cnt++;
    always @(negedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            chk("rdata", exp_q.pop_front(), rdata);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        idle(8);
        arst_n = 1'b1;
        rd_reg(`RTCX_HOURS_ADDR, 8'h00);
        rd_reg(`RTCX_INTCMP_ADDR, 8'h00);
        rd_reg(`RTCX_NOMTRIM_ADDR, 8'h00);
        rd_reg(`RTCX_TMPTRIM_ADDR, 8'h00);
        rd_reg(`RTCX_PINCFG_ADDR, 8'h00);
        rd_reg(8'h10, 8'h00);
        chk1("cal_oe_n", 1'b1, cal_oe_n);
        wr_reg(`RTCX_HOURS_ADDR, 8'h09);
        rd_reg(`RTCX_HOURS_ADDR, 8'h00);
        kwr(`RTCX_HOURS_ADDR, 8'h04);
        wr_reg(`RTCX_HOURS_ADDR, 8'h07);
        rd_reg(`RTCX_HOURS_ADDR, 8'h04);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            tv = (i < 2) ? ((i == 0) ? 16'h6432 : 16'h9CCE) : lfsr[15:0];
            wr_reg(`RTCX_NOMTRIM_ADDR, tv[15:8]);
            wr_reg(`RTCX_TMPTRIM_ADDR, tv[7:0]);
            rd_reg(`RTCX_NOMTRIM_ADDR, tv[15:8]);
            rd_reg(`RTCX_TMPTRIM_ADDR, tv[7:0]);
            idle(3);
            chk("comp", clamp(tv[15:8], tv[7:0]), comp);
        end
        kwr(`RTCX_PINCFG_ADDR, 8'h81);
        @(negedge clk);
        soft_rst = 1'b1;
        @(negedge clk);
        soft_rst = 1'b0;
        rd_reg(`RTCX_HOURS_ADDR, 8'h04);
        rd_reg(`RTCX_NOMTRIM_ADDR, tv[15:8]);
        rd_reg(`RTCX_TMPTRIM_ADDR, tv[7:0]);
        rd_reg(`RTCX_PINCFG_ADDR, 8'h00);
        $display("test registers done");
        for (int m = 0; m < 3; m++) begin
            cfg.hour_format_select = (m == 0);
            h = (m == 1) ? 8'hFE : 8'h16;
            kwr(`RTCX_HOURS_ADDR, h);
            n0 = irq_cnt;
            w = 0;
            repeat (2) begin
                pulse(8'h01, 1);
                v = cfg.hour_format_select ? 8'h17 : 8'hFF;
                w = w + int'(h == v);
                h = (h == v) ? 8'h00 : h + 8'h01;
            end
            idle(3);
            rd_reg(`RTCX_HOURS_ADDR, h);
            chk1("day", w[0], day);
            chk("irq_count", 8'(w), 8'(irq_cnt - n0));
            idle(6);
            chk1("day", w[0], day);
            pulse(8'h40, 1);
            idle(2);
            chk1("day", 1'b0, day);
        end
        $display("test hours done");
        lfsr = nxt(lfsr);
        n = 8'h02 + {6'h00, lfsr[1:0]};
        sel = int'(lfsr[3:2]);
        wr_reg(`RTCX_INTCMP_ADDR, n);
        pulse(8'h02, 2);
        idle(2);
        rd_reg(`RTCX_INTCMP_ADDR, n);
        cfg.timebase_sel = lfsr[3:2];
        cfg.single_interval = 1'b1;
        cfg.interval_enable = 1'b1;
        idle(2);
        n0 = irq_cnt;
        pulse(8'h04 << (sel ^ 1), 3);
        pulse(8'h04 << sel, int'(n) - 1);
        idle(3);
        chk1("alarm", 1'b0, alarm);
        pulse(8'h04 << sel, 1);
        idle(3);
        chk1("alarm", 1'b1, alarm);
        pulse(8'h04 << sel, int'(n) + 2);
        idle(3);
        chk("irq_count", 8'h01, 8'(irq_cnt - n0));
        chk1("alarm", 1'b1, alarm);
        pulse(8'h80, 1);
        idle(2);
        chk1("alarm", 1'b0, alarm);
        // A held counter rearms only through the enable or a soft reset
        cfg.single_interval = 1'b0;
        cfg.interval_enable = 1'b0;
        idle(2);
        cfg.interval_enable = 1'b1;
        idle(2);
        pulse(8'h04 << sel, 2 * int'(n));
        idle(3);
        chk("irq_count", 8'h03, 8'(irq_cnt - n0));
        wr_reg(`RTCX_INTCMP_ADDR, 8'hFF);
        pulse(8'h02, 2);
        idle(2);
        pulse(8'h04 << sel, 254);
        idle(3);
        chk("irq_count", 8'h03, 8'(irq_cnt - n0));
        pulse(8'h04 << sel, 1);
        idle(3);
        chk("irq_count", 8'h04, 8'(irq_cnt - n0));
        $display("test alarm done");
        for (int c = 0; c < 8; c++) begin
            v = {1'b1, c[1:0], 1'b0, c[2:0], c[0]};
            kwr(`RTCX_PINCFG_ADDR, v);
            wave = 4'h1 << c[1:0];
            idle(4);
            chk1("cal", 1'b1, cal);
            chk1("cal_oe_n", 1'b0, cal_oe_n);
            wave = ~wave;
            idle(3);
            chk1("cal", 1'b0, cal);
            chk1("gpio", c[1:0] == 2'b00, gpio);
            chk1("bat", c[1:0] == 2'b01, bat);
            chk1("irq1", c[2:1] == 2'b11, i1);
            chk1("irq0", c[0], i0);
            p0 = 1'b0;
            p1 = 1'b0;
            idle(4);
            chk1("pins_low", 1'b0, i0 | i1 | bat | gpio);
            p0 = 1'b1;
            p1 = 1'b1;
        end
        kwr(`RTCX_PINCFG_ADDR, 8'h00);
        idle(4);
        chk1("cal_oe_n", 1'b1, cal_oe_n);
        $display("test pins done");
        complete_run();
    end
endmodule
`default_nettype wire
